/* File: design/acc_pkg.sv */
package acc_pkg;
  // data-space and io-space offsets of the registers
  localparam logic [7:0] ACC_CTRL_STATUS_OFS = 8'h50;
  localparam logic [7:0] ACC_IO_SPACE_BIAS = 8'h20;
  localparam logic [7:0] ACC_CTRL_STATUS_IO = 8'h30;
  localparam logic [7:0] ACC_PIN_DISABLE_OFS = 8'h7f;
  // control/status field positions
  localparam int ACC_POWER_OFF_BIT = 7;
  localparam int ACC_BANDGAP_BIT = 6;
  localparam int ACC_OUTPUT_BIT = 5;
  localparam int ACC_FLAG_BIT = 4;
  localparam int ACC_IRQ_EN_BIT = 3;
  localparam int ACC_CAPTURE_BIT = 2;
  localparam int ACC_MODE_HI_BIT = 1;
  localparam int ACC_MODE_LO_BIT = 0;
  // pin input disable field positions
  localparam int ACC_POS_OFF_BIT = 0;
  localparam int ACC_NEG_OFF_BIT = 1;
  // values after reset
  localparam logic [7:0] ACC_CTRL_RESET = 8'h00;
  localparam logic [7:0] ACC_PIN_DISABLE_RESET = 8'h00;
  localparam logic [7:0] ACC_PIN_DISABLE_MASK = 8'h03;
  // synchroniser depth in cycles
  localparam int ACC_SYNC_STAGES = 2;
  // interrupt mode encodings
  localparam logic [1:0] ACC_MODE_TOGGLE = 2'h0;
  localparam logic [1:0] ACC_MODE_RESERVED = 2'h1;
  localparam logic [1:0] ACC_MODE_FALL = 2'h2;
  localparam logic [1:0] ACC_MODE_RISE = 2'h3;
  // negative input selection
  typedef enum logic [3:0] {
    ACC_NEG_CH0, ACC_NEG_CH1, ACC_NEG_CH2, ACC_NEG_CH3,
    ACC_NEG_CH4, ACC_NEG_CH5, ACC_NEG_CH6, ACC_NEG_CH7,
    ACC_NEG_PIN
  } acc_neg_sel_t;
endpackage

/* File: design/acc_sync.sv */
`timescale 1ns/100ps
// two-stage synchroniser with edge outputs taken after the second stage
module acc_sync (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic async_in,
  output logic sync_q,
  output logic rise_q,
  output logic fall_q
);
  logic meta_q;
  logic hold_q;

  // two flops only, so the output lags the pin by one to two cycles
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  // edges compare the synchronised value with its last sample
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      hold_q <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end
    else
    begin
      hold_q <= sync_q;
      rise_q <= sync_q & ~hold_q;
      fall_q <= ~sync_q & hold_q;
    end
  end
endmodule

/* File: design/acc_ctrl.sv */
`timescale 1ns/100ps
// Contract
// - mux on, converter off: channel picks negative
// - otherwise negative pin feeds negative input
// - power-off bit 7 removes comparator power
// - bandgap bit 6 selects positive reference
// - result synchronised to bit 5, 1-2 cycles
// - matching event sets flag bit 4
// - vector ack or write-one clears flag
// - request needs enable bit 3 and global
// - capture bit 2 routes output to timer
// - mode bits 1:0 select toggle/fall/rise
// - disable bits gate pin input buffers
// - upper six disable bits read zero
// - control reachable at 0x50 and 0x30
// - result high when positive exceeds negative
module acc_ctrl (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] data_addr,
  input wire logic [5:0] io_addr,
  input wire logic data_wr,
  input wire logic data_rd,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data_q,
  input wire logic comparator_mux_enable,
  input wire logic converter_enable,
  input wire logic [2:0] channel_select_low,
  input wire logic global_irq_enable,
  input wire logic irq_vector_ack,
  input wire logic comparator_raw,
  input wire logic positive_pin_in,
  input wire logic negative_pin_in,
  output logic comparator_power_off_q,
  output logic bandgap_select_q,
  output logic [3:0] negative_select_q,
  output logic capture_trigger_q,
  output logic comparator_irq_q,
  output logic positive_pin_buf_en_q,
  output logic negative_pin_buf_en_q,
  output logic positive_pin_port_q,
  output logic negative_pin_port_q
);
  logic comparator_power_off_q_r;
  logic bandgap_select_r;
  logic comparator_irq_flag_q;
  logic comparator_irq_enable_q;
  logic capture_route_enable_q;
  logic [1:0] irq_mode_q;
  logic positive_pin_input_off_q;
  logic negative_pin_input_off_q;
  logic comparator_output_sync;
  logic out_rise;
  logic out_fall;
  logic ctrl_wr;
  logic ctrl_rd;
  logic dis_wr;
  logic dis_rd;
  logic event_hit;
  logic [7:0] ctrl_view;
  logic [7:0] dis_view;
  logic [1:0] pos_pin_sync_q;
  logic [1:0] neg_pin_sync_q;
  logic [3:0] neg_sel_d;

  // true for a data-space hit or the aliased io-space hit
  function automatic logic ctrl_hit(input logic [7:0] da, input logic ds, input logic [5:0] ia,
                                    input logic is);
    ctrl_hit = (ds && da == acc_pkg::ACC_CTRL_STATUS_OFS) ||
               (is && {2'h0, ia} == acc_pkg::ACC_CTRL_STATUS_OFS - acc_pkg::ACC_IO_SPACE_BIAS);
  endfunction

  assign ctrl_wr = ctrl_hit(data_addr, data_wr, io_addr, io_wr);
  assign ctrl_rd = ctrl_hit(data_addr, data_rd, io_addr, io_rd);
  assign dis_wr = data_wr && data_addr == acc_pkg::ACC_PIN_DISABLE_OFS;
  assign dis_rd = data_rd && data_addr == acc_pkg::ACC_PIN_DISABLE_OFS;

  // comparator_raw is high when positive input exceeds negative
  acc_sync u_out_sync (
    .clk(clk),
    .rst_b(rst_b),
    .async_in(comparator_raw),
    .sync_q(comparator_output_sync),
    .rise_q(out_rise),
    .fall_q(out_fall)
  );

  // control bits
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      comparator_power_off_q_r <= acc_pkg::ACC_CTRL_RESET[acc_pkg::ACC_POWER_OFF_BIT];
      bandgap_select_r <= acc_pkg::ACC_CTRL_RESET[acc_pkg::ACC_BANDGAP_BIT];
      comparator_irq_enable_q <= acc_pkg::ACC_CTRL_RESET[acc_pkg::ACC_IRQ_EN_BIT];
      capture_route_enable_q <= acc_pkg::ACC_CTRL_RESET[acc_pkg::ACC_CAPTURE_BIT];
      irq_mode_q <= acc_pkg::ACC_CTRL_RESET[acc_pkg::ACC_MODE_HI_BIT:acc_pkg::ACC_MODE_LO_BIT];
    end
    else if (ctrl_wr)
    begin
      comparator_power_off_q_r <= wr_data[acc_pkg::ACC_POWER_OFF_BIT];
      bandgap_select_r <= wr_data[acc_pkg::ACC_BANDGAP_BIT];
      comparator_irq_enable_q <= wr_data[acc_pkg::ACC_IRQ_EN_BIT];
      capture_route_enable_q <= wr_data[acc_pkg::ACC_CAPTURE_BIT];
      irq_mode_q <= wr_data[acc_pkg::ACC_MODE_HI_BIT:acc_pkg::ACC_MODE_LO_BIT];
    end
  end

  // event match on synchronised sample pairs
  always_comb
  begin
    case (irq_mode_q)
      acc_pkg::ACC_MODE_TOGGLE: event_hit = out_rise | out_fall;
      acc_pkg::ACC_MODE_FALL: event_hit = out_fall;
      acc_pkg::ACC_MODE_RISE: event_hit = out_rise;
      default: event_hit = 1'b0;
    endcase
  end

  // flag: a new event wins over either clear
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      comparator_irq_flag_q <= acc_pkg::ACC_CTRL_RESET[acc_pkg::ACC_FLAG_BIT];
    else if (event_hit)
      comparator_irq_flag_q <= 1'b1;
    else if (irq_vector_ack || (ctrl_wr && wr_data[acc_pkg::ACC_FLAG_BIT]))
      comparator_irq_flag_q <= 1'b0;
  end

  // pin input disable register
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      positive_pin_input_off_q <= acc_pkg::ACC_PIN_DISABLE_RESET[acc_pkg::ACC_POS_OFF_BIT];
      negative_pin_input_off_q <= acc_pkg::ACC_PIN_DISABLE_RESET[acc_pkg::ACC_NEG_OFF_BIT];
    end
    else if (dis_wr)
    begin
      positive_pin_input_off_q <= wr_data[acc_pkg::ACC_POS_OFF_BIT];
      negative_pin_input_off_q <= wr_data[acc_pkg::ACC_NEG_OFF_BIT];
    end
  end

  always_comb
  begin
    ctrl_view = 8'h00;
    ctrl_view[acc_pkg::ACC_POWER_OFF_BIT] = comparator_power_off_q_r;
    ctrl_view[acc_pkg::ACC_BANDGAP_BIT] = bandgap_select_r;
    ctrl_view[acc_pkg::ACC_OUTPUT_BIT] = comparator_output_sync;
    ctrl_view[acc_pkg::ACC_FLAG_BIT] = comparator_irq_flag_q;
    ctrl_view[acc_pkg::ACC_IRQ_EN_BIT] = comparator_irq_enable_q;
    ctrl_view[acc_pkg::ACC_CAPTURE_BIT] = capture_route_enable_q;
    ctrl_view[acc_pkg::ACC_MODE_HI_BIT:acc_pkg::ACC_MODE_LO_BIT] = irq_mode_q;
    dis_view = 8'h00;
    dis_view[acc_pkg::ACC_POS_OFF_BIT] = positive_pin_input_off_q;
    dis_view[acc_pkg::ACC_NEG_OFF_BIT] = negative_pin_input_off_q;
    dis_view = dis_view & acc_pkg::ACC_PIN_DISABLE_MASK;
  end

  // read data registered; unmapped reads return zero
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      rd_data_q <= 8'h00;
    else if (ctrl_rd)
      rd_data_q <= ctrl_view;
    else if (dis_rd)
      rd_data_q <= dis_view;
    else
      rd_data_q <= 8'h00;
  end

  // negative input choice
  always_comb
  begin
    if (comparator_mux_enable && !converter_enable)
      neg_sel_d = {1'b0, channel_select_low};
    else
      neg_sel_d = 4'(acc_pkg::ACC_NEG_PIN);
  end

  // pin inputs into the port reading pass these two flops and then the output register, three flops in all
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      pos_pin_sync_q <= 2'h0;
      neg_pin_sync_q <= 2'h0;
    end
    else
    begin
      pos_pin_sync_q <= {pos_pin_sync_q[0], positive_pin_in};
      neg_pin_sync_q <= {neg_pin_sync_q[0], negative_pin_in};
    end
  end

  // registered outputs
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      comparator_power_off_q <= 1'b0;
      bandgap_select_q <= 1'b0;
      negative_select_q <= 4'(acc_pkg::ACC_NEG_PIN);
      capture_trigger_q <= 1'b0;
      comparator_irq_q <= 1'b0;
      positive_pin_buf_en_q <= 1'b1;
      negative_pin_buf_en_q <= 1'b1;
      positive_pin_port_q <= 1'b0;
      negative_pin_port_q <= 1'b0;
    end
    else
    begin
      comparator_power_off_q <= comparator_power_off_q_r;
      bandgap_select_q <= bandgap_select_r;
      negative_select_q <= neg_sel_d;
      capture_trigger_q <= capture_route_enable_q & comparator_output_sync;
      comparator_irq_q <= comparator_irq_flag_q & comparator_irq_enable_q
                          & global_irq_enable;
      positive_pin_buf_en_q <= ~positive_pin_input_off_q;
      negative_pin_buf_en_q <= ~negative_pin_input_off_q;
      positive_pin_port_q <= pos_pin_sync_q[1] & ~positive_pin_input_off_q;
      negative_pin_port_q <= neg_pin_sync_q[1] & ~negative_pin_input_off_q;
    end
  end

  // helper: synchronised output one cycle late
  logic sync_prev_q;
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      sync_prev_q <= 1'b0;
    else
      sync_prev_q <= comparator_output_sync;
  end

  flag_rise_a: assert property (@(posedge clk) disable iff (!rst_b)
    (irq_mode_q == acc_pkg::ACC_MODE_RISE && out_rise) |=> comparator_irq_flag_q)
    else $error("flag not set on rising event");

  flag_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
    (irq_vector_ack && !event_hit) |=> !comparator_irq_flag_q)
    else $error("flag not cleared by vector");

  irq_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
    comparator_irq_q |-> $past(comparator_irq_enable_q) && $past(global_irq_enable))
    else $error("irq raised without enables");

  neg_pin_a: assert property (@(posedge clk) disable iff (!rst_b)
    (!comparator_mux_enable || converter_enable)
    |=> negative_select_q == 4'(acc_pkg::ACC_NEG_PIN))
    else $error("negative pin not selected");

  neg_chan_a: assert property (@(posedge clk) disable iff (!rst_b)
    (comparator_mux_enable && !converter_enable)
    |=> negative_select_q == {1'b0, $past(channel_select_low)})
    else $error("channel not selected");

  sync_lat_a: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(comparator_raw) ##1 comparator_raw [*2] |-> comparator_output_sync)
    else $error("sync latency too long");

  no_reserved_a: assert property (@(posedge clk) disable iff (!rst_b)
    irq_mode_q == acc_pkg::ACC_MODE_RESERVED |-> ##1 !$rose(comparator_irq_flag_q))
    else $error("reserved mode set flag");

  pin_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
    positive_pin_input_off_q |=> !positive_pin_port_q && !positive_pin_buf_en_q)
    else $error("disabled pin reads nonzero");

  capture_a: assert property (@(posedge clk) disable iff (!rst_b)
    capture_trigger_q |-> $past(capture_route_enable_q) && sync_prev_q)
    else $error("capture route without enable");

  alias_a: assert property (@(posedge clk) disable iff (!rst_b)
    (io_wr && io_addr == acc_pkg::ACC_CTRL_STATUS_IO[5:0] && !data_wr)
    |=> bandgap_select_r == $past(wr_data[acc_pkg::ACC_BANDGAP_BIT]))
    else $error("io alias write missed");

  neg_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
    negative_pin_input_off_q |=> !negative_pin_port_q && !negative_pin_buf_en_q)
    else $error("disabled negative pin reads nonzero");

  flag_fall_a: assert property (@(posedge clk) disable iff (!rst_b)
    (irq_mode_q == acc_pkg::ACC_MODE_FALL && out_fall) |=> comparator_irq_flag_q)
    else $error("flag not set on falling event");

  flag_toggle_a: assert property (@(posedge clk) disable iff (!rst_b)
    (irq_mode_q == acc_pkg::ACC_MODE_TOGGLE && (out_rise || out_fall))
    |=> comparator_irq_flag_q)
    else $error("flag not set on toggle event");

  flag_wclr_a: assert property (@(posedge clk) disable iff (!rst_b)
    (ctrl_wr && wr_data[acc_pkg::ACC_FLAG_BIT] && !event_hit) |=> !comparator_irq_flag_q)
    else $error("flag not cleared by write");

  dis_read_a: assert property (@(posedge clk) disable iff (!rst_b)
    (dis_rd && !ctrl_rd) |=> rd_data_q[7:2] == 6'h00)
    else $error("reserved disable bits read nonzero");
endmodule

/* File: verif/acc_far_model.sv */
`timescale 1ns/100ps
// analog core and timer capture front end
module acc_far_model #(
  parameter logic [7:0] BANDGAP_LV = 8'h80
) (
  input wire logic clk,
  input wire logic power_off,
  input wire logic bandgap_sel,
  input wire logic [3:0] neg_sel,
  input wire logic capture_in,
  input wire logic cap_irq_en,
  input wire logic [7:0] pos_lv,
  input wire logic [7:0] neg_lv,
  input wire logic [63:0] ch_lv,
  output logic raw,
  output logic [7:0] cap_cnt
);
  logic [7:0] pos_v;
  logic [7:0] neg_v;
  logic cap_q = 1'b0;
  logic [7:0] cnt_q = 8'h00;
  assign pos_v = bandgap_sel ? BANDGAP_LV : pos_lv;
  assign neg_v = (neg_sel < 4'h8) ? ch_lv[neg_sel[2:0]*8 +: 8] : neg_lv;
  assign raw = !power_off && (pos_v > neg_v);
  assign cap_cnt = cnt_q;
  // capture interrupts counted only while the timer enables them
  always @(posedge clk)
  begin
    cap_q <= capture_in;
    if (capture_in && !cap_q && cap_irq_en)
      cnt_q <= cnt_q + 8'h01;
  end
endmodule

/* File: verif/comparator_control_logic_bench.sv */
`timescale 1ns/100ps
module comparator_control_logic_bench;
  localparam logic [7:0] CS = acc_pkg::ACC_CTRL_STATUS_OFS;
  localparam logic [7:0] IO = acc_pkg::ACC_CTRL_STATUS_IO;
  localparam logic [7:0] DIS = acc_pkg::ACC_PIN_DISABLE_OFS;
  logic clk = 1'b0, rst_b = 1'b0;
  logic [7:0] data_addr = 8'h00, wr_data = 8'h00, rd_data_q, v, c;
  logic [5:0] io_addr = 6'h00;
  logic data_wr = 1'b0, data_rd = 1'b0, io_wr = 1'b0, io_rd = 1'b0;
  logic comparator_mux_enable = 1'b0, converter_enable = 1'b0;
  logic [2:0] channel_select_low = 3'h0;
  logic global_irq_enable = 1'b0, irq_vector_ack = 1'b0, comparator_raw;
  logic positive_pin_in = 1'b1, negative_pin_in = 1'b1;
  logic comparator_power_off_q, bandgap_select_q, capture_trigger_q, comparator_irq_q;
  logic [3:0] negative_select_q;
  logic positive_pin_buf_en_q, negative_pin_buf_en_q, positive_pin_port_q, negative_pin_port_q;
  logic [7:0] pos_lv = 8'h10, neg_lv = 8'h20, cap_cnt;
  logic [63:0] ch_lv = 64'h7868584838281808;
  logic timer_capture_irq_enable = 1'b0;
  int n_fail = 0, n_compared = 0, cyc = 0;
  acc_ctrl uut (
    .clk(clk),
    .rst_b(rst_b),
    .data_addr(data_addr),
    .io_addr(io_addr),
    .data_wr(data_wr),
    .data_rd(data_rd),
    .io_wr(io_wr),
    .io_rd(io_rd),
    .wr_data(wr_data),
    .rd_data_q(rd_data_q),
    .comparator_mux_enable(comparator_mux_enable),
    .converter_enable(converter_enable),
    .channel_select_low(channel_select_low),
    .global_irq_enable(global_irq_enable),
    .irq_vector_ack(irq_vector_ack),
    .comparator_raw(comparator_raw),
    .positive_pin_in(positive_pin_in),
    .negative_pin_in(negative_pin_in),
    .comparator_power_off_q(comparator_power_off_q),
    .bandgap_select_q(bandgap_select_q),
    .negative_select_q(negative_select_q),
    .capture_trigger_q(capture_trigger_q),
    .comparator_irq_q(comparator_irq_q),
    .positive_pin_buf_en_q(positive_pin_buf_en_q),
    .negative_pin_buf_en_q(negative_pin_buf_en_q),
    .positive_pin_port_q(positive_pin_port_q),
    .negative_pin_port_q(negative_pin_port_q)
  );
  acc_far_model far (.clk(clk), .power_off(comparator_power_off_q),
    .bandgap_sel(bandgap_select_q), .neg_sel(negative_select_q),
    .capture_in(capture_trigger_q), .cap_irq_en(timer_capture_irq_enable),
    .pos_lv(pos_lv), .neg_lv(neg_lv),
    .ch_lv(ch_lv), .raw(comparator_raw), .cap_cnt(cap_cnt));
  initial forever #2.5 clk = ~clk;
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input bit io, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    data_addr <= a;
    io_addr <= a[5:0];
    wr_data <= d;
    data_wr <= !io;
    io_wr <= io;
    @(posedge clk);
    data_wr <= 1'b0;
    io_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk);
    data_addr <= a;
    data_rd <= 1'b1;
    @(posedge clk);
    data_rd <= 1'b0;
    #1 v = rd_data_q;
  endtask
  task rdio;
    @(posedge clk);
    io_addr <= IO[5:0];
    io_rd <= 1'b1;
    @(posedge clk);
    io_rd <= 1'b0;
    #1 v = rd_data_q;
  endtask
  task w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task lv(input logic [7:0] p);
    @(posedge clk);
    pos_lv <= p;
    w(6);
  endtask
  task t_regs;
    rd(DIS);
    chk(v, 8'h00);
    chk(negative_select_q, 8'h08);
    wr(1, IO, 8'h40);
    rd(CS);
    chk(v & 8'hdf, 8'h40);
    rd(CS);
    chk(v, 8'h60);
    rdio;
    chk(v, 8'h70);
    chk(bandgap_select_q, 1'b1);
    rd(8'h51);
    chk(v, 8'h00);
    wr(1, IO, 8'h00);
    wr(0, DIS, 8'hff);
    rd(DIS);
    chk(v, 8'h03);
    w(4);
    chk({positive_pin_buf_en_q, negative_pin_buf_en_q, positive_pin_port_q,
      negative_pin_port_q}, 8'h00);
    wr(0, DIS, 8'h00);
    w(5);
    chk({positive_pin_buf_en_q, negative_pin_buf_en_q, positive_pin_port_q,
      negative_pin_port_q}, 8'h0f);
  endtask
  task t_mux;
    @(posedge clk);
    comparator_mux_enable <= 1'b1;
    pos_lv <= 8'h40;
    for (int k = 0; k < 8; k++)
    begin
      @(posedge clk);
      channel_select_low <= k[2:0];
      w(6);
      chk(negative_select_q, k[7:0]);
      rd(CS);
      chk(v[5], k < 4);
    end
    @(posedge clk);
    converter_enable <= 1'b1;
    w(3);
    chk(negative_select_q, 8'h08);
    @(posedge clk);
    comparator_mux_enable <= 1'b0;
    converter_enable <= 1'b0;
    w(3);
    chk(negative_select_q, 8'h08);
  endtask
  task t_modes;
    logic [1:0] m;
    for (int i = 0; i < 4; i++)
    begin
      m = i[1:0];
      lv(8'h10);
      wr(0, CS, {6'h04, m});
      lv(8'h30);
      rd(CS);
      chk(v, {3'b001, m == 2'h0 || m == 2'h3, 2'b00, m});
      wr(0, CS, {6'h04, m});
      lv(8'h10);
      rd(CS);
      chk(v, {3'b000, m == 2'h0 || m == 2'h2, 2'b00, m});
    end
  endtask
  task t_irq;
    wr(0, CS, 8'h13);
    wr(0, CS, 8'h1b);
    @(posedge clk);
    global_irq_enable <= 1'b1;
    lv(8'h30);
    chk(comparator_irq_q, 1'b1);
    @(posedge clk);
    global_irq_enable <= 1'b0;
    w(3);
    chk(comparator_irq_q, 1'b0);
    @(posedge clk);
    global_irq_enable <= 1'b1;
    @(posedge clk);
    irq_vector_ack <= 1'b1;
    @(posedge clk);
    irq_vector_ack <= 1'b0;
    rd(CS);
    chk(v, 8'h2b);
    chk(comparator_irq_q, 1'b0);
    lv(8'h10);
    lv(8'h30);
    chk(comparator_irq_q, 1'b1);
    wr(0, CS, 8'h13);
    rd(CS);
    chk(v, 8'h23);
    chk(comparator_irq_q, 1'b0);
  endtask
  task t_cap;
    @(posedge clk);
    timer_capture_irq_enable <= 1'b1;
    wr(0, CS, 8'h04);
    lv(8'h10);
    c = cap_cnt;
    lv(8'h30);
    chk(capture_trigger_q, 1'b1);
    chk(cap_cnt, c + 8'h01);
    wr(0, CS, 8'h00);
    lv(8'h10);
    lv(8'h30);
    chk(cap_cnt, c + 8'h01);
    chk(capture_trigger_q, 1'b0);
  endtask
  task t_power;
    wr(0, CS, 8'h91);
    w(6);
    chk(comparator_power_off_q, 1'b1);
    rd(CS);
    chk(v, 8'h81);
    wr(0, CS, 8'h01);
    w(6);
    rd(CS);
    chk(v, 8'h21);
  endtask
  task report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_fail++;
      report_and_stop;
    end
  end
  initial
  begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    t_regs;
    t_mux;
    t_modes;
    t_irq;
    t_cap;
    t_power;
    report_and_stop;
  end
endmodule
